// File: rtl/difl_consts.vh
// Constants for the drive input function logic
// Function
// - Free-run-stop input cuts motor output at once; motor coasts.
// - On free-run-stop release, mode 00 restarts at 0 Hz, else synchronises.
// - Restart delay accepts 0.3 to 100 s, defaults 1.0 s, times restarts.
// - Function codes 11 free-run stop, 12 external fault, 13 restart inhibit.
// - Input function codes 18 fault acknowledge, 06 inching mode.
// - External fault input raises external fault code and stops the drive.
// - External fault stays latched after input release until acknowledged.
// - Acknowledge comes from fault-acknowledge input or keypad OFF key.
// - After acknowledge the motor restarts at once if run is still present.
// - Inhibit input blocks restart at supply return with run; sets its code.
// - Inhibit fault clears on OFF key, acknowledge input, or run withdrawn; with inhibit input and run held, the first acknowledge only disarms it.
// - Inhibit still enforced after undervoltage acknowledged by the input.
// - Acknowledge input acts on activation followed by deactivation only.
// - Acknowledge input is always active high, never invertible.
// - Acknowledge while motor runs switches output off; motor coasts.
// - Inching plus run applies inching frequency directly, no ramp.
// - Inching frequency 0.5 to 9.99 Hz, default 1.0, changeable in run.
// - Inching stop: 00 coast, 01 deceleration ramp, 02 DC braking.
// - Run source 01 terminals forward/reverse, 02 keypad ON key.
// - Inching refused while inching frequency below minimum start frequency.
`ifndef DIFL_CONSTS_VH
`define DIFL_CONSTS_VH

// Register byte offsets
`define DIFL_OFS_FSEL_LO 8'h00
`define DIFL_OFS_FSEL_HI 8'h04
`define DIFL_OFS_CFG 8'h08
`define DIFL_OFS_DELAY 8'h0C
`define DIFL_OFS_INCH 8'h10
`define DIFL_OFS_MINF 8'h14
`define DIFL_OFS_SETF 8'h18
`define DIFL_OFS_STAT 8'h1C

// Configuration field positions
`define DIFL_CFG_RESUME 1:0
`define DIFL_CFG_SRC 9:8
`define DIFL_CFG_ISTOP 17:16

// Input function codes
`define DIFL_FN_FWD 8'h00
`define DIFL_FN_REV 8'h01
`define DIFL_FN_INCH 8'h06
`define DIFL_FN_FRS 8'h0B
`define DIFL_FN_EXT 8'h0C
`define DIFL_FN_INH 8'h0D
`define DIFL_FN_ACK 8'h12
`define DIFL_FN_NONE 8'hFF

// Fault codes
`define DIFL_FLT_NONE 8'h00
`define DIFL_FLT_UV 8'h09
`define DIFL_FLT_EXT 8'h0C
`define DIFL_FLT_INH 8'h0D

// Mode values
`define DIFL_RESUME_ZERO 2'h0
`define DIFL_SRC_TERM 2'h1
`define DIFL_SRC_KEY 2'h2
`define DIFL_ISTOP_COAST 2'h0
`define DIFL_ISTOP_RAMP 2'h1
`define DIFL_ISTOP_DC 2'h2

// Reset values; delay in 0.1 s, frequencies in 0.01 Hz
`define DIFL_RST_FSEL_LO 32'hFFFF_FFFF
`define DIFL_RST_FSEL_HI 32'h0000_FFFF
`define DIFL_RST_CFG 32'h0000_0100
`define DIFL_RST_DELAY 16'h000A
`define DIFL_MIN_DELAY 16'h0003
`define DIFL_MAX_DELAY 16'h03E8
`define DIFL_RST_INCH 16'h0064
`define DIFL_MIN_INCH 16'h0032
`define DIFL_MAX_INCH 16'h03E7
`define DIFL_RST_MINF 16'h0032
`define DIFL_RST_SETF 16'h0000

// Timing: delay tick of 100 ms at 200 MHz
`define DIFL_CLK_MHZ 200
`define DIFL_TICK_MS 100
`define DIFL_TICK_CYC (`DIFL_TICK_MS * `DIFL_CLK_MHZ * 1000)

`endif

// File: rtl/difl_top.v
// Digital input function logic of the drive with its APB register file
`timescale 1ns/1ps
`default_nettype none
`include "difl_consts.vh"

module difl_top #(
    parameter integer TICK_CYC = `DIFL_TICK_CYC
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Terminal and keypad pins
    input wire [5:0] digital_input,
    input wire on_key,
    input wire off_key,
    input wire supply_ok,
    // From the output-frequency stage
    input wire motor_standstill,
    // To the output-frequency stage
    output reg output_enable,
    output reg [15:0] frequency_command,
    output reg ramp_bypass,
    output reg decel_ramp_stop,
    output reg dc_brake,
    output reg speed_sync,
    output reg reverse_dir,
    // Fault indication
    output reg [7:0] fault_code,
    output reg fault_relay_contact
);

    localparam [2:0] ST_STOP = 3'h0;
    localparam [2:0] ST_RUN = 3'h1;
    localparam [2:0] ST_INCH = 3'h2;
    localparam [2:0] ST_COAST = 3'h3;
    localparam [2:0] ST_WAIT = 3'h4;
    localparam [2:0] ST_BRAKE = 3'h5;
    localparam [2:0] ST_FAULT = 3'h6;

    // Registers
    reg [31:0] fsel_lo_q;
    reg [31:0] fsel_hi_q;
    reg [31:0] cfg_q;
    reg [15:0] delay_q;
    reg [15:0] inch_q;
    reg [15:0] minf_q;
    reg [15:0] setf_q;

    // Synchronisers: six terminals, ON, OFF, supply
    reg [8:0] s1_q;
    reg [8:0] s2_q;
    reg [8:0] s3_q;
    reg [8:0] filt_q;
    wire [8:0] filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg ack_prev_q;
    reg off_prev_q;
    reg sup_prev_q;
    reg key_run_q;
    reg pwr_ret_q;
    reg hold_q;
    reg [31:0] tick_q;
    reg [15:0] dcnt_q;

    // Selections and levels go in as arguments so every caller follows them
    wire [47:0] fsel_all = {fsel_hi_q[15:0], fsel_lo_q};
    wire [5:0] term_lvl = filt_q[5:0];

    // Any terminal programmed with this function and active
    function fn_active;
        input [7:0] code;
        input [47:0] sel;
        input [5:0] act;
        integer i;
        begin
            fn_active = 1'b0;
            for (i = 0; i < 6; i = i + 1) begin
                if (sel[i*8 +: 8] == code && act[i])
                    fn_active = 1'b1;
            end
        end
    endfunction

    // Out-of-range settings are pulled to the nearest limit
    function [15:0] clamp;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            if (v < lo)
                clamp = lo;
            else if (v > hi)
                clamp = hi;
            else
                clamp = v;
        end
    endfunction

    wire frs_in = fn_active(`DIFL_FN_FRS, fsel_all, term_lvl);
    wire ext_in = fn_active(`DIFL_FN_EXT, fsel_all, term_lvl);
    wire inh_in = fn_active(`DIFL_FN_INH, fsel_all, term_lvl);
    wire ack_in = fn_active(`DIFL_FN_ACK, fsel_all, term_lvl);
    wire inch_in = fn_active(`DIFL_FN_INCH, fsel_all, term_lvl);
    wire fwd_in = fn_active(`DIFL_FN_FWD, fsel_all, term_lvl);
    wire rev_in = fn_active(`DIFL_FN_REV, fsel_all, term_lvl);
    wire on_k = filt_q[6];
    wire off_k = filt_q[7];
    wire sup = filt_q[8];

    // Acknowledge on release of the input, not its level
    wire ack_in_evt = ack_prev_q & ~ack_in;
    wire off_evt = off_k & ~off_prev_q;
    wire ack_evt = ack_in_evt | off_evt;

    wire [1:0] src = cfg_q[`DIFL_CFG_SRC];
    wire term_run = fwd_in ^ rev_in;
    wire run_cmd = (src == `DIFL_SRC_KEY) ? key_run_q : term_run;
    wire inch_ok = inch_in & (inch_q >= minf_q);
    wire [1:0] istop = cfg_q[`DIFL_CFG_ISTOP];
    wire motor_on = (state_q == ST_RUN) | (state_q == ST_INCH);
    wire delay_done = (dcnt_q == 16'h0000);

    // Fault latch; a new event wins over a simultaneous acknowledge
    reg [7:0] flt_d;
    always @* begin
        flt_d = fault_code;
        if (ack_evt)
            flt_d = `DIFL_FLT_NONE;
        if (fault_code == `DIFL_FLT_INH && !run_cmd)
            flt_d = `DIFL_FLT_NONE;
        if (!sup && motor_on)
            flt_d = `DIFL_FLT_UV;
        if (sup && pwr_ret_q && inh_in && run_cmd && !motor_on)
            flt_d = `DIFL_FLT_INH;
        if (ext_in)
            flt_d = `DIFL_FLT_EXT;
    end

    wire flt_any = (flt_d != `DIFL_FLT_NONE);

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_STOP: begin
                if (run_cmd && sup && !hold_q && !frs_in) begin
                    if (inch_in) begin
                        if (inch_ok)
                            state_d = ST_INCH;
                    end else begin
                        state_d = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (!run_cmd)
                    state_d = ST_STOP;
            end
            ST_INCH: begin
                if (!run_cmd || !inch_ok) begin
                    if (istop == `DIFL_ISTOP_COAST)
                        state_d = ST_STOP;
                    else
                        state_d = ST_BRAKE;
                end
            end
            ST_BRAKE: begin
                if (motor_standstill)
                    state_d = ST_STOP;
            end
            ST_COAST: begin
                if (!frs_in) begin
                    if (cfg_q[`DIFL_CFG_RESUME] == `DIFL_RESUME_ZERO)
                        state_d = ST_STOP;
                    else
                        state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!run_cmd)
                    state_d = ST_STOP;
                else if (delay_done)
                    state_d = ST_RUN;
            end
            ST_FAULT: begin
                if (!flt_any)
                    state_d = ST_STOP;
            end
            default: begin
                state_d = ST_STOP;
            end
        endcase
        // Highest priority: faults, then acknowledge in motion, then free-run stop
        if (frs_in && state_d != ST_FAULT)
            state_d = ST_COAST;
        if (ack_evt && motor_on)
            state_d = ST_STOP;
        if (flt_any)
            state_d = ST_FAULT;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 9'h000;
            s2_q <= 9'h000;
            s3_q <= 9'h000;
            filt_q <= 9'h000;
            ack_prev_q <= 1'b0;
            off_prev_q <= 1'b0;
            sup_prev_q <= 1'b0;
            key_run_q <= 1'b0;
            pwr_ret_q <= 1'b1;
            hold_q <= 1'b0;
            state_q <= ST_STOP;
            fault_code <= `DIFL_FLT_NONE;
            tick_q <= 32'h0000_0000;
            dcnt_q <= 16'h0000;
        end else begin
            s1_q <= {supply_ok, off_key, on_key, digital_input};
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
            ack_prev_q <= ack_in;
            off_prev_q <= off_k;
            sup_prev_q <= sup;
            state_q <= state_d;
            fault_code <= flt_d;
            if (off_k)
                key_run_q <= 1'b0;
            else if (on_k)
                key_run_q <= 1'b1;
            // Supply return arms the inhibit; motor start, run withdrawal or an acknowledge of the inhibit fault disarms it
            if (sup && !sup_prev_q)
                pwr_ret_q <= 1'b1;
            else if (motor_on || !run_cmd)
                pwr_ret_q <= 1'b0;
            else if (ack_evt && fault_code == `DIFL_FLT_INH)
                pwr_ret_q <= 1'b0;
            // Acknowledge in motion coasts; restart waits for run release
            if (ack_evt && motor_on)
                hold_q <= 1'b1;
            else if (!run_cmd)
                hold_q <= 1'b0;
            // Delay counter in 0.1 s ticks, loaded on entering the wait
            if (state_q != ST_WAIT) begin
                tick_q <= 32'h0000_0000;
                dcnt_q <= delay_q;
            end else if (tick_q == TICK_CYC - 1) begin
                tick_q <= 32'h0000_0000;
                if (!delay_done)
                    dcnt_q <= dcnt_q - 16'h0001;
            end else begin
                tick_q <= tick_q + 32'h0000_0001;
            end
        end
    end

    // Motor-side outputs, registered from the next state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_enable <= 1'b0;
            frequency_command <= 16'h0000;
            ramp_bypass <= 1'b0;
            decel_ramp_stop <= 1'b0;
            dc_brake <= 1'b0;
            speed_sync <= 1'b0;
            reverse_dir <= 1'b0;
            fault_relay_contact <= 1'b0;
        end else begin
            output_enable <= (state_d == ST_RUN) | (state_d == ST_INCH) |
                (state_d == ST_BRAKE);
            ramp_bypass <= (state_d == ST_INCH);
            decel_ramp_stop <= (state_d == ST_BRAKE) &
                (istop == `DIFL_ISTOP_RAMP);
            dc_brake <= (state_d == ST_BRAKE) &
                (istop == `DIFL_ISTOP_DC);
            if (state_q == ST_WAIT && state_d == ST_RUN)
                speed_sync <= 1'b1;
            else if (state_d != ST_RUN)
                speed_sync <= 1'b0;
            if (state_d == ST_INCH)
                frequency_command <= inch_q;
            else if (state_d == ST_RUN)
                frequency_command <= setf_q;
            else
                frequency_command <= 16'h0000;
            if (state_d == ST_STOP && src == `DIFL_SRC_TERM)
                reverse_dir <= rev_in;
            fault_relay_contact <= flt_any;
        end
    end

    // APB: one wait state, so every access takes setup plus two cycles
    wire acc = psel & penable & pready;
    wire mapped = (paddr[1:0] == 2'h0) && (paddr <= `DIFL_OFS_STAT);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            fsel_lo_q <= `DIFL_RST_FSEL_LO;
            fsel_hi_q <= `DIFL_RST_FSEL_HI;
            cfg_q <= `DIFL_RST_CFG;
            delay_q <= `DIFL_RST_DELAY;
            inch_q <= `DIFL_RST_INCH;
            minf_q <= `DIFL_RST_MINF;
            setf_q <= `DIFL_RST_SETF;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel && !penable) begin
                case (paddr)
                    `DIFL_OFS_FSEL_LO: prdata <= fsel_lo_q;
                    `DIFL_OFS_FSEL_HI: prdata <= {16'h0000, fsel_hi_q[15:0]};
                    `DIFL_OFS_CFG: prdata <= cfg_q;
                    `DIFL_OFS_DELAY: prdata <= {16'h0000, delay_q};
                    `DIFL_OFS_INCH: prdata <= {16'h0000, inch_q};
                    `DIFL_OFS_MINF: prdata <= {16'h0000, minf_q};
                    `DIFL_OFS_SETF: prdata <= {16'h0000, setf_q};
                    `DIFL_OFS_STAT: prdata <= {filt_q[5:0], hold_q,
                        pwr_ret_q, 5'h00, state_q, output_enable,
                        fault_relay_contact, 6'h00, fault_code};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
            if (acc && pwrite) begin
                case (paddr)
                    `DIFL_OFS_FSEL_LO: fsel_lo_q <= pwdata;
                    `DIFL_OFS_FSEL_HI: fsel_hi_q <= {16'h0000, pwdata[15:0]};
                    `DIFL_OFS_CFG: cfg_q <= pwdata & 32'h0003_0303;
                    `DIFL_OFS_DELAY: delay_q <= clamp(pwdata[15:0],
                        `DIFL_MIN_DELAY, `DIFL_MAX_DELAY);
                    `DIFL_OFS_INCH: inch_q <= clamp(pwdata[15:0],
                        `DIFL_MIN_INCH, `DIFL_MAX_INCH);
                    `DIFL_OFS_MINF: minf_q <= pwdata[15:0];
                    `DIFL_OFS_SETF: setf_q <= pwdata[15:0];
                    default: begin
                    end
                endcase
            end
        end
    end

endmodule // difl_top
`default_nettype wire

// File: sim/difl_props.sv
// Port assertions for the drive input function logic
`timescale 1ns/1ps
`default_nettype none
module difl_props #(
    parameter integer TICK_CYC = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic [5:0] digital_input,
    input wire logic off_key,
    // Motor link and fault
    input wire logic output_enable,
    input wire logic [15:0] frequency_command,
    input wire logic ramp_bypass,
    input wire logic decel_ramp_stop,
    input wire logic dc_brake,
    input wire logic speed_sync,
    input wire logic [7:0] fault_code,
    input wire logic fault_relay_contact
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
a_fault_off: assert property ((fault_code != 8'h00) [*2]
    |-> !output_enable)
    else $error("motor output on with fault latched");
a_relay_fault: assert property ($stable(fault_code) |->
    fault_relay_contact == (fault_code != 8'h00))
    else $error("relay does not follow fault");
a_freq_zero: assert property (!output_enable |-> frequency_command == 0)
    else $error("frequency with output off");
// Eight quiet cycles let any earlier pin change settle through the filter
a_ext_latch: assert property ((!off_key && $stable(digital_input)) [*8]
    ##0 fault_code == 8'h0C |=> fault_code != 8'h00)
    else $error("external fault cleared without acknowledge");
a_brake_excl: assert property (!(dc_brake && decel_ramp_stop))
    else $error("two stop methods at once");
a_sync_run: assert property (speed_sync |-> output_enable)
    else $error("speed sync with output off");
c_ext: cover property (fault_code == 8'h0C);
c_inh: cover property (fault_code == 8'h0D);
c_sync: cover property (speed_sync);
c_inch: cover property (ramp_bypass && output_enable);
endmodule // difl_props
bind difl_top difl_props #(.TICK_CYC(TICK_CYC)) u_difl_props (.pclk,
    .presetn, .psel, .penable, .pready, .pslverr, .digital_input, .off_key,
    .output_enable, .frequency_command, .ramp_bypass, .decel_ramp_stop,
    .dc_brake, .speed_sync, .fault_code, .fault_relay_contact);
`default_nettype wire

// File: sim/difl_switches.sv
// Operator switch model for terminal, keypad and supply pins
`timescale 1ns/1ps
`default_nettype none
module difl_switches (
    // Clock
    input wire logic pclk,
    // Pins
    output logic [5:0] digital_input,
    output logic on_key,
    output logic off_key,
    output logic supply_ok
);
initial begin
    digital_input = 6'h00;
    on_key = 1'b0;
    off_key = 1'b0;
    supply_ok = 1'b1;
end
// Levels last 8 cycles before the task returns
task drive(input int w, input logic v);
    @(posedge pclk);
    case (w)
        6: on_key <= v;
        7: off_key <= v;
        8: supply_ok <= v;
        default: digital_input[w] <= v;
    endcase
    repeat (8) @(posedge pclk);
endtask
endmodule // difl_switches
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking testbench for the drive input function logic
`timescale 1ns/1ps
`default_nettype none
`include "difl_consts.vh"
module tb_top;
logic pclk = 1'b0;
logic presetn = 1'b0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic snap = 1'b0;
logic motor_standstill = 1'b1;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0000_0000;
logic [31:0] r;
logic [64:0] q[$];
int miscompares = 0;
int cmp_count = 0;
wire [31:0] prdata;
wire [15:0] frequency_command;
wire [7:0] fault_code;
wire [5:0] digital_input;
wire pready, pslverr, on_key, off_key, supply_ok, output_enable;
wire speed_sync, ramp_bypass, decel_ramp_stop, dc_brake, reverse_dir;
wire fault_relay_contact;
wire [31:0] pw = {output_enable, speed_sync, ramp_bypass, decel_ramp_stop,
    dc_brake, reverse_dir, fault_relay_contact, 1'b0, fault_code,
    frequency_command};
localparam logic [31:0] ALL = 32'hFFFF_FFFF;
always #2.5 pclk = ~pclk;
difl_top #(.TICK_CYC(10)) u_difl_top (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .digital_input,
    .on_key, .off_key, .supply_ok, .motor_standstill, .output_enable,
    .frequency_command, .ramp_bypass, .decel_ramp_stop, .dc_brake,
    .speed_sync, .reverse_dir, .fault_code, .fault_relay_contact);
difl_switches u_difl_switches (.pclk, .digital_input, .on_key, .off_key,
    .supply_ok);
task tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
task chk(input logic [64:0] e, input logic [31:0] g, input logic err);
    cmp_count++;
    if ((g & e[63:32]) !== e[31:0] || err !== e[64]) begin
        miscompares++;
        $display("wrong value at %0t: got %h want %h", $time, g, e[31:0]);
    end
endtask
// Results come from read completions and from port snapshots
always @(posedge pclk) begin
    if (snap || (psel && penable && pready === 1'b1 && !pwrite)) begin
        if (q.size() == 0) begin
            miscompares++;
            $display("wrong value at %0t: no expected result queued", $time);
        end else begin
            chk(q.pop_front(), snap ? pw : prdata, snap ? 1'b0 : pslverr);
        end
    end
end
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
        @(posedge pclk);
        n++;
    end while (pready !== 1'b1 && n < 40);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) begin
        miscompares++;
        tally_and_finish();
    end
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
endtask
task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input logic err);
    q.push_back({err, m, e});
    apb(1'b0, a, 32'h0000_0000);
endtask
task st(input logic [31:0] e);
    rd(`DIFL_OFS_STAT, 32'h0000_C0FF, e, 1'b0);
endtask
task pt(input logic [31:0] m, input logic [31:0] e);
    q.push_back({1'b0, m, e});
    @(posedge pclk);
    snap <= 1'b1;
    @(posedge pclk);
    snap <= 1'b0;
endtask
task pin(input int i, input logic v);
    u_difl_switches.drive(i, v);
endtask
initial begin
    r = $urandom(38256);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`DIFL_OFS_FSEL_LO, ALL, `DIFL_RST_FSEL_LO, 1'b0);
    rd(`DIFL_OFS_FSEL_HI, ALL, `DIFL_RST_FSEL_HI, 1'b0);
    rd(`DIFL_OFS_CFG, ALL, `DIFL_RST_CFG, 1'b0);
    rd(`DIFL_OFS_DELAY, ALL, {16'h0, `DIFL_RST_DELAY}, 1'b0);
    rd(`DIFL_OFS_INCH, ALL, {16'h0, `DIFL_RST_INCH}, 1'b0);
    rd(`DIFL_OFS_MINF, ALL, {16'h0, `DIFL_RST_MINF}, 1'b0);
    rd(8'h20, ALL, 32'h0000_0000, 1'b1);
    rd(8'h06, ALL, 32'h0000_0000, 1'b1);
    wr(`DIFL_OFS_STAT, ALL);
    st(32'h0000_0000);
    wr(`DIFL_OFS_DELAY, 32'h0000_FFFF);
    rd(`DIFL_OFS_DELAY, ALL, {16'h0, `DIFL_MAX_DELAY}, 1'b0);
    wr(`DIFL_OFS_DELAY, 32'h0000_0001);
    rd(`DIFL_OFS_DELAY, ALL, {16'h0, `DIFL_MIN_DELAY}, 1'b0);
    wr(`DIFL_OFS_INCH, 32'h0000_0001);
    rd(`DIFL_OFS_INCH, ALL, {16'h0, `DIFL_MIN_INCH}, 1'b0);
    wr(`DIFL_OFS_INCH, 32'h0000_FFFF);
    rd(`DIFL_OFS_INCH, ALL, {16'h0, `DIFL_MAX_INCH}, 1'b0);
    repeat (3) begin
        r = $urandom;
        wr(`DIFL_OFS_SETF, r);
        rd(`DIFL_OFS_SETF, 32'h0000_FFFF, r & 32'h0000_FFFF, 1'b0);
    end
    wr(`DIFL_OFS_FSEL_LO, {`DIFL_FN_FRS, `DIFL_FN_ACK, `DIFL_FN_EXT,
        `DIFL_FN_FWD});
    wr(`DIFL_OFS_FSEL_HI, {16'h0, `DIFL_FN_INCH, `DIFL_FN_INH});
    pin(0, 1'b1);
    st(32'h0000_8000);
    pin(1, 1'b1);
    st(32'h0000_400C);
    pin(1, 1'b0);
    st(32'h0000_400C);
    pin(2, 1'b1);
    st(32'h0000_400C);
    pin(2, 1'b0);
    st(32'h0000_8000);
    pin(1, 1'b1);
    pin(1, 1'b0);
    pin(7, 1'b1);
    pin(7, 1'b0);
    st(32'h0000_8000);
    pin(2, 1'b1);
    pin(2, 1'b0);
    st(32'h0000_0000);
    pin(0, 1'b0);
    pin(0, 1'b1);
    pin(3, 1'b1);
    st(32'h0000_0000);
    pin(3, 1'b0);
    pt(32'hC000_0000, 32'h8000_0000);
    wr(`DIFL_OFS_CFG, 32'h0000_0101);
    pin(3, 1'b1);
    pin(3, 1'b0);
    pt(32'hC000_0000, 32'h0000_0000);
    repeat (40) @(posedge pclk);
    pt(32'hC000_0000, 32'hC000_0000);
    pin(4, 1'b1);
    pin(8, 1'b0);
    st(32'h0000_4009);
    pin(8, 1'b1);
    pin(2, 1'b1);
    pin(2, 1'b0);
    st(32'h0000_400D);
    pin(0, 1'b0);
    st(32'h0000_0000);
    pin(4, 1'b0);
    wr(`DIFL_OFS_CFG, 32'h0000_0201);
    pin(6, 1'b1);
    pin(6, 1'b0);
    st(32'h0000_8000);
    pin(7, 1'b1);
    pin(7, 1'b0);
    st(32'h0000_0000);
    wr(`DIFL_OFS_INCH, 32'h0000_01C2);
    pin(5, 1'b1);
    for (int s = 0; s < 3; s++) begin
        wr(`DIFL_OFS_CFG, {14'h0, s[1:0], 16'h0101});
        motor_standstill <= 1'b0;
        pin(0, 1'b1);
        pt(32'hA000_FFFF, 32'hA000_01C2);
        pin(0, 1'b0);
        pt(32'h1800_0000 | (s == 0 ? 32'h8000_0000 : 32'h0),
            {3'b000, s == 1, s == 2, 27'h0});
        motor_standstill <= 1'b1;
        repeat (4) @(posedge pclk);
        pt(32'h1800_0000, 32'h0000_0000);
    end
    wr(`DIFL_OFS_MINF, 32'h0000_01F4);
    pin(0, 1'b1);
    pt(32'h8000_0000, 32'h0000_0000);
    pin(0, 1'b0);
    wr(`DIFL_OFS_FSEL_HI, {16'h0, `DIFL_FN_INCH, `DIFL_FN_REV});
    pin(4, 1'b1);
    pt(32'h8400_0000, 32'h0400_0000);
    tally_and_finish();
end
endmodule // tb_top
`default_nettype wire
